/* verilog/wit_top.sv */
`timescale 1ns/1ps
// What this block does
// - Four prescaled count clocks, overflow 2^11..2^17
// - Clock select register, bits 2..0, reset 00H
// - Mode register: run bit7, mode bits 4,3
// - Writing run 1 clears counter, starts
// - Run bit cannot be cleared by software
// - Mode bits sticky once set until reset
// - Interval mode: overflow raises maskable request
// - Watchdog mode 1: overflow raises NMI
// - Watchdog mode 2: overflow starts system reset
// - Interval counting starts only with run bit
// - Run clear leaves prescaler; first interval shorter
// - Watchdog select with flag set raises NMI
// - Counts in halt, freezes in stop
// - Mask gates interval interrupt, highest priority
`include "wit_regs.svh"

module wit_top
    import wit_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_b_i,
    input  wire wit_bus_req_t bus_req_i,
    output logic [7:0]        bus_rdata_o,
    input  wire logic         irq_flag_clr_i,
    input  wire logic         watchdog_irq_mask_i,
    input  wire logic         stop_mode_i,
    output logic              watchdog_irq_flag_o,
    output logic              watchdog_interval_irq_o,
    output logic              nmi_req_o,
    output logic              sys_reset_req_o
);

    logic [2:0]              clk_sel_q;
    logic                    run_q;
    logic                    mode_hi_q;
    logic                    mode_lo_q;
    logic [`WIT_PRESC_W-1:0] presc_q;
    logic [`WIT_CNT_W-1:0]   cnt_q;
    logic                    flag_q;
    logic                    irq_q;
    logic                    nmi_q;
    logic                    rst_req_q;
    logic [7:0]              rdata_q;

    logic                    sel_wr;
    logic                    mode_wr;
    logic                    run_restart;
    logic                    count_tick;
    logic                    overflow;
    logic                    mode_hi_new;
    logic                    late_nmi;
    wit_mode_t               mode;
    logic                    ovf_nmi;
    logic                    ovf_rst;

    // Address decode of the two registers
    always_comb begin
        sel_wr  = 1'b0;
        mode_wr = 1'b0;
        if (bus_req_i.wr && bus_req_i.addr == `WIT_CLK_SEL_ADDR) begin
            sel_wr = 1'b1;
        end else if (bus_req_i.wr && bus_req_i.addr == `WIT_MODE_CTRL_ADDR) begin
            mode_wr = 1'b1;
        end
    end

    assign mode        = wit_mode_t'({mode_hi_q, mode_lo_q});
    assign run_restart = mode_wr && bus_req_i.wdata[`WIT_RUN_BIT];

    // Clock select register; only the documented codes are meaningful
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_sel_q <= 3'(`WIT_CLK_SEL_RST);
        end else if (sel_wr) begin
            clk_sel_q <= bus_req_i.wdata[`WIT_SEL_MSB:`WIT_SEL_LSB];
        end
    end

    // Run bit: set by software, cleared only by reset
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_q <= 1'(`WIT_MODE_CTRL_RST >> `WIT_RUN_BIT);
        end else if (run_restart) begin
            run_q <= 1'b1;
        end
    end

    // Mode bits: a written 1 sticks, a written 0 is ignored
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_hi_q <= 1'b0;
            mode_lo_q <= 1'b0;
        end else if (mode_wr) begin
            mode_hi_q <= mode_hi_q | bus_req_i.wdata[`WIT_MODE_HI_BIT];
            mode_lo_q <= mode_lo_q | bus_req_i.wdata[`WIT_MODE_LO_BIT];
        end
    end

    // Free running prescaler, frozen in stop, never cleared by run writes
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_q <= '0;
        end else if (!stop_mode_i) begin
            presc_q <= presc_q + `WIT_PRESC_W'(1);
        end
    end

    // Count clock tick taken from the selected prescaler tap
    always_comb begin
        count_tick = 1'b0;
        case (clk_sel_q)
            `WIT_SEL_DIV16:   count_tick = &presc_q[3:0];
            `WIT_SEL_DIV64:   count_tick = &presc_q[5:0];
            `WIT_SEL_DIV256:  count_tick = &presc_q[7:0];
            `WIT_SEL_DIV1024: count_tick = &presc_q[9:0];
            default:          count_tick = 1'b0;
        endcase
        if (stop_mode_i) begin
            count_tick = 1'b0;
        end
    end

    // Overflow only while running and a mode is chosen
    assign overflow = run_q && count_tick && (cnt_q == `WIT_CNT_LAST)
                      && (mode != WIT_MODE_OFF);

    // Overflow action per mode; interval and off raise no non-maskable event
    always_comb begin
        ovf_nmi = 1'b0;
        ovf_rst = 1'b0;
        case (mode)
            WIT_MODE_WD_NMI: begin
                ovf_nmi = overflow;
            end
            WIT_MODE_WD_RESET: begin
                ovf_rst = overflow;
            end
            default: begin
                ovf_nmi = 1'b0;
                ovf_rst = 1'b0;
            end
        endcase
    end

    // Main counter: cleared by a run write, wraps after overflow
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else if (run_restart) begin
            cnt_q <= '0;
        end else if (run_q && count_tick) begin
            cnt_q <= cnt_q + `WIT_CNT_W'(1);
        end
    end

    // Watchdog mode newly chosen by this write
    assign mode_hi_new = mode_wr && !mode_hi_q && bus_req_i.wdata[`WIT_MODE_HI_BIT];
    assign late_nmi    = mode_hi_new && flag_q;

    // Interrupt request flag: overflow sets, clear input clears, set wins
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_q <= 1'b0;
        end else if (overflow) begin
            flag_q <= 1'b1;
        end else if (irq_flag_clr_i) begin
            flag_q <= 1'b0;
        end
    end

    // Maskable interval request, gated by the mask flag
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (mode == WIT_MODE_INTERVAL) && !watchdog_irq_mask_i
                     && (flag_q || overflow);
        end
    end

    // Non-maskable request pulse
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= ovf_nmi
                     || late_nmi;
        end
    end

    // System reset request, held until the reset input acts
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_req_q <= 1'b0;
        end else if (ovf_rst) begin
            rst_req_q <= 1'b1;
        end
    end

    // Read data, registered; unmapped addresses read zero
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 8'h00;
        end else if (bus_req_i.rd) begin
            if (bus_req_i.addr == `WIT_CLK_SEL_ADDR) begin
                rdata_q <= {5'h00, clk_sel_q};
            end else if (bus_req_i.addr == `WIT_MODE_CTRL_ADDR) begin
                rdata_q <= {run_q, 2'h0, mode_hi_q, mode_lo_q, 3'h0};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign bus_rdata_o             = rdata_q;
    assign watchdog_irq_flag_o     = flag_q;
    assign watchdog_interval_irq_o = irq_q;
    assign nmi_req_o               = nmi_q;
    assign sys_reset_req_o         = rst_req_q;

endmodule

/* common/wit_regs.svh */
`ifndef WIT_REGS_SVH
`define WIT_REGS_SVH

// Register addresses on the CPU data bus
`define WIT_CLK_SEL_ADDR      16'hFF42
`define WIT_MODE_CTRL_ADDR    16'hFFF9

// Reset values
`define WIT_CLK_SEL_RST       8'h00
`define WIT_MODE_CTRL_RST     8'h00

// Field positions in the mode control register
`define WIT_RUN_BIT           7
`define WIT_MODE_HI_BIT       4
`define WIT_MODE_LO_BIT       3

// Field positions in the clock select register
`define WIT_SEL_MSB           2
`define WIT_SEL_LSB           0

// Clock select codes and prescaler tap widths (divide by 2^n)
`define WIT_SEL_DIV16         3'h0
`define WIT_SEL_DIV64         3'h2
`define WIT_SEL_DIV256        3'h4
`define WIT_SEL_DIV1024       3'h6
`define WIT_PRESC_W           10

// Counter: 2^7 count-clock ticks to overflow for every setting
`define WIT_CNT_W             7
`define WIT_CNT_LAST          7'h7F

// Base clock period in ns
`define WIT_CLK_PERIOD_NS     4

`endif

/* common/wit_pkg.sv */
package wit_pkg;

    // Operating mode, from mode bits hi and lo
    typedef enum logic [1:0] {
        WIT_MODE_OFF      = 2'b00,
        WIT_MODE_INTERVAL = 2'b01,
        WIT_MODE_WD_NMI   = 2'b10,
        WIT_MODE_WD_RESET = 2'b11
    } wit_mode_t;

    // CPU bus request toward the block
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } wit_bus_req_t;

endpackage

/* test/wit_properties.sv */
`timescale 1ns/1ps
`include "wit_regs.svh"
module wit_properties
    import wit_pkg::*;
(
    input wire logic         sys_clk_i,
    input wire logic         rst_b_i,
    input wire wit_bus_req_t bus_req_i,
    input wire logic [7:0]   bus_rdata_o,
    input wire logic         irq_flag_clr_i,
    input wire logic         watchdog_irq_mask_i,
    input wire logic         watchdog_irq_flag_o,
    input wire logic         watchdog_interval_irq_o,
    input wire logic         nmi_req_o,
    input wire logic         sys_reset_req_o
);
    // Reads aimed at one of the two registers
    wire rd_sel  = bus_req_i.rd && bus_req_i.addr == `WIT_CLK_SEL_ADDR;
    wire rd_mode = bus_req_i.rd && bus_req_i.addr == `WIT_MODE_CTRL_ADDR;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Request outputs
    a_nmi_pulse: assert property (nmi_req_o |=> !nmi_req_o)
        else $error("nmi longer than one cycle");
    a_rst_req_hold: assert property (sys_reset_req_o |=> sys_reset_req_o)
        else $error("reset request dropped");
    a_irq_mask_gate: assert property (watchdog_interval_irq_o |->
        (watchdog_irq_flag_o || $past(watchdog_irq_flag_o)) && !$past(watchdog_irq_mask_i))
        else $error("interval irq without flag or while masked");
    a_nmi_has_flag: assert property (nmi_req_o |->
        watchdog_irq_flag_o || $past(watchdog_irq_flag_o))
        else $error("nmi without request flag");
    // Request flag
    a_flag_hold: assert property (watchdog_irq_flag_o && !irq_flag_clr_i |=>
        watchdog_irq_flag_o) else $error("flag lost without clear");
    a_flag_clr_only: assert property ($fell(watchdog_irq_flag_o) |-> $past(irq_flag_clr_i))
        else $error("flag fell without clear");
    // Read data
    a_unmapped_zero: assert property (bus_req_i.rd && !rd_sel && !rd_mode |=>
        bus_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_sel_high_zero: assert property (rd_sel |=> bus_rdata_o[7:3] == 5'h00)
        else $error("select upper bits not zero");
    a_mode_rsvd_zero: assert property (rd_mode |=>
        {bus_rdata_o[6:5], bus_rdata_o[2:0]} == 5'h00) else $error("mode spare bits set");
    c_nmi: cover property (nmi_req_o);
    c_rst: cover property (sys_reset_req_o);
    c_irq: cover property (watchdog_interval_irq_o);
endmodule

bind wit_top wit_properties i_props (.sys_clk_i, .rst_b_i, .bus_req_i, .bus_rdata_o,
    .irq_flag_clr_i, .watchdog_irq_mask_i, .watchdog_irq_flag_o, .watchdog_interval_irq_o,
    .nmi_req_o, .sys_reset_req_o);

/* test/wit_top_tb.sv */
`timescale 1ns/1ps
module wit_top_tb
    import wit_pkg::*;
;
    logic         sys_clk_i, rst_b_i, irq_flag_clr_i, watchdog_irq_mask_i, stop_mode_i;
    wit_bus_req_t bus_req_i;
    logic [7:0]   bus_rdata_o;
    logic         watchdog_irq_flag_o, watchdog_interval_irq_o, nmi_req_o, sys_reset_req_o;
    int           failures, check_count;

    wit_top i_dut (.sys_clk_i, .rst_b_i, .bus_req_i, .bus_rdata_o, .irq_flag_clr_i,
        .watchdog_irq_mask_i, .stop_mode_i, .watchdog_irq_flag_o, .watchdog_interval_irq_o,
        .nmi_req_o, .sys_reset_req_o);

    // Base clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge sys_clk_i) rst_b_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
    endtask

    // One bus cycle, taken at the second edge
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge sys_clk_i) bus_req_i <= '{a, w, !w, d};
        @(posedge sys_clk_i) bus_req_i <= '{a, 1'b0, 1'b0, d};
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        @(posedge sys_clk_i) #1 check(bus_rdata_o === e, bus_rdata_o, e);
    endtask

    task automatic idle_chk(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1 check(watchdog_irq_flag_o === 1'b0, watchdog_irq_flag_o, 0);
    endtask

    // Cycles to the flag; the request outputs rise on the same edge as the flag
    task automatic measure(input int lo, input int hi, input logic [2:0] e, input logic clr);
        int n = 0;
        do @(posedge sys_clk_i) #1 n++;
        while (watchdog_irq_flag_o !== 1'b1 && n < 40000);
        check(n >= lo && n <= hi, n, hi);
        if (n >= 40000) test_done();
        check({watchdog_interval_irq_o, nmi_req_o, sys_reset_req_o} === e,
              {watchdog_interval_irq_o, nmi_req_o, sys_reset_req_o}, e);
        @(posedge sys_clk_i) irq_flag_clr_i <= clr;
        @(posedge sys_clk_i) irq_flag_clr_i <= 1'b0;
    endtask

    task automatic t_regs();
        rdchk(16'hFF42, 8'h00);
        rdchk(16'hFFF9, 8'h00);
        rdchk(16'hFF43, 8'h00);
        bus(16'hFF42, 1'b1, 8'hFE);
        rdchk(16'hFF42, 8'h06);
        bus(16'hFF42, 1'b1, 8'h00);
    endtask

    task automatic t_interval();
        bus(16'hFFF9, 1'b1, 8'h08);
        idle_chk(2100);
        bus(16'hFFF9, 1'b1, 8'h88);
        measure(2033, 2048, 3'b100, 1'b1);
        watchdog_irq_mask_i <= 1'b1;
        measure(2046, 2046, 3'b000, 1'b1);
        bus(16'hFFF9, 1'b1, 8'h00);
        rdchk(16'hFFF9, 8'h88);
        stop_mode_i <= 1'b1;
        idle_chk(3000);
        stop_mode_i <= 1'b0;
        watchdog_irq_mask_i <= 1'b0;
        bus(16'hFF42, 1'b1, 8'h02);
        bus(16'hFFF9, 1'b1, 8'h80);
        measure(8129, 8192, 3'b100, 1'b1);
        bus(16'hFF42, 1'b1, 8'h04);
        bus(16'hFFF9, 1'b1, 8'h80);
        measure(32513, 32768, 3'b100, 1'b1);
    endtask

    task automatic t_nmi();
        do_reset();
        #1 check(watchdog_irq_flag_o === 1'b0, watchdog_irq_flag_o, 0);
        bus(16'hFFF9, 1'b1, 8'h90);
        repeat (3) begin
            idle_chk(1500);
            bus(16'hFFF9, 1'b1, 8'h90);
        end
        measure(2033, 2048, 3'b010, 1'b1);
    endtask

    // Mode off, late watchdog select with the flag set, then mode 2
    task automatic t_reset_mode();
        do_reset();
        bus(16'hFFF9, 1'b1, 8'h80);
        idle_chk(2100);
        bus(16'hFFF9, 1'b1, 8'h88);
        measure(2033, 2048, 3'b100, 1'b0);
        bus(16'hFFF9, 1'b1, 8'h10);
        #1 check(nmi_req_o === 1'b1, nmi_req_o, 1);
        @(posedge sys_clk_i) irq_flag_clr_i <= 1'b1;
        @(posedge sys_clk_i) irq_flag_clr_i <= 1'b0;
        bus(16'hFFF9, 1'b1, 8'h80);
        measure(2033, 2048, 3'b001, 1'b1);
        rdchk(16'hFFF9, 8'h98);
        do_reset();
        #1 check(sys_reset_req_o === 1'b0, sys_reset_req_o, 0);
        rdchk(16'hFFF9, 8'h00);
    endtask

    // Main sequence
    initial begin
        rst_b_i = 1'b0;
        irq_flag_clr_i = 1'b0;
        watchdog_irq_mask_i = 1'b0;
        stop_mode_i = 1'b0;
        bus_req_i = '0;
        failures = 0;
        check_count = 0;
        do_reset();
        t_regs();
        t_interval();
        t_nmi();
        t_reset_mode();
        test_done();
    end
endmodule
